// *** logic/power_mode_pkg.sv ***
package power_mode_pkg;

  // ********************************************************************
  // Mode encoding and interrupt mask values
  // ********************************************************************
  typedef enum logic [2:0] {
    MODE_RUN        = 3'b000,
    MODE_WAIT       = 3'b001,
    MODE_ACT_HALT   = 3'b010,
    MODE_FULL_HALT  = 3'b011,
    MODE_STABILISE  = 3'b100
  } power_mode_e;

  localparam logic [1:0] MASK_LEVEL_ALL_ENABLED = 2'b10;
  localparam logic [1:0] MASK_LEVEL_RESET       = 2'b11;
  localparam int         DIV_SELECT_WIDTH       = 2;
  localparam int         DIV_COUNT_WIDTH        = 4;

  // ********************************************************************
  // Wake stabilisation delays in master clock cycles
  // ********************************************************************
  localparam int WAKE_DELAY_SHORT_CYCLES = 256;
  localparam int WAKE_DELAY_LONG_CYCLES  = 4096;
  localparam int WAKE_COUNT_WIDTH        = 13;

endpackage : power_mode_pkg

// *** logic/slow_clock_divider.sv ***
`timescale 1ns/1ns
// Produces a one-cycle enable every 2, 4, 8 or 16 master clocks.
module slow_clock_divider (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       slow_mode_enable_i,
  input  wire logic [1:0] slow_divider_select_i,
  output logic            tick_o
);

  logic [power_mode_pkg::DIV_COUNT_WIDTH-1:0] count_q;
  logic [1:0]                                 sel_q;
  logic                                       en_q;
  logic [power_mode_pkg::DIV_COUNT_WIDTH-1:0] limit;

  // Ratio 2^(sel+1); terminal count is ratio minus one.
  assign limit = 4'((5'd2 << sel_q) - 5'd1);

  // Settings are adopted only at a period boundary so no short pulse appears.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q <= 4'h0;
      sel_q   <= 2'h0;
      en_q    <= 1'b0;
    end else if (!en_q || count_q >= limit) begin
      count_q <= 4'h0;
      sel_q   <= slow_divider_select_i;
      en_q    <= slow_mode_enable_i;
    end else begin
      count_q <= count_q + 4'h1;
    end
  end

  // Without slow mode every master clock is a CPU clock.
  assign tick_o = !en_q || count_q >= limit;

endmodule : slow_clock_divider

// *** logic/power_mode_controller.sv ***
`timescale 1ns/1ns
// Power-mode sequencer: clock gating enables, mask forcing and wake timing.
module power_mode_controller (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       slow_mode_enable_i,
  input  wire logic [1:0] slow_divider_select_i,
  input  wire logic       oscillator_interrupt_enable_i,
  input  wire logic       long_delay_option_i,
  input  wire logic       watchdog_halt_option_i,
  input  wire logic       watchdog_enabled_i,
  input  wire logic       wait_for_interrupt_i,
  input  wire logic       halt_exec_i,
  input  wire logic       irq_any_i,
  input  wire logic       irq_timebase_i,
  input  wire logic       irq_halt_wake_i,
  input  wire logic       irq_push_i,
  input  wire logic [1:0] irq_priority_i,
  input  wire logic       irq_pop_i,
  input  wire logic [1:0] mask_level_wr_data_i,
  input  wire logic       mask_level_wr_i,
  output logic            cpu_clk_en_o,
  output logic            periph_clk_en_o,
  output logic            timebase_clk_en_o,
  output logic            oscillator_on_o,
  output logic [1:0]      mask_level_o,
  output logic            wake_service_o,
  output logic            watchdog_reset_req_o,
  output logic            watchdog_suppress_o,
  output logic [2:0]      mode_o
);

  // ********************************************************************
  // Wake inputs synchronised
  // ********************************************************************
  // Interrupt lines may arrive from pins; three stages, change when 2 and 3 agree.
  logic [2:0] halt_wake_sync_q;
  logic [2:0] timebase_sync_q;
  logic       halt_wake_seen_q;
  logic       timebase_seen_q;

  // Shift chains for the two asynchronous wake sources.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_wake_sync_q <= 3'h0;
      timebase_sync_q  <= 3'h0;
    end else begin
      halt_wake_sync_q <= {halt_wake_sync_q[1:0], irq_halt_wake_i};
      timebase_sync_q  <= {timebase_sync_q[1:0], irq_timebase_i};
    end
  end

  // Filtered level updates only when the last two stages agree.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_wake_seen_q <= 1'b0;
      timebase_seen_q  <= 1'b0;
    end else begin
      if (halt_wake_sync_q[2] == halt_wake_sync_q[1]) begin
        halt_wake_seen_q <= halt_wake_sync_q[2];
      end
      if (timebase_sync_q[2] == timebase_sync_q[1]) begin
        timebase_seen_q <= timebase_sync_q[2];
      end
    end
  end

  // ********************************************************************
  // Slow clock enable
  // ********************************************************************
  logic slow_tick;

  slow_clock_divider u_divider (
    .clk_i                 (clk_i),
    .arst_n_i              (arst_n_i),
    .slow_mode_enable_i    (slow_mode_enable_i),
    .slow_divider_select_i (slow_divider_select_i),
    .tick_o                (slow_tick)
  );

  // ********************************************************************
  // Mode state machine
  // ********************************************************************
  power_mode_pkg::power_mode_e mode_q;
  power_mode_pkg::power_mode_e mode_d;
  logic [power_mode_pkg::WAKE_COUNT_WIDTH-1:0] delay_q;
  logic [power_mode_pkg::WAKE_COUNT_WIDTH-1:0] delay_d;
  logic [power_mode_pkg::WAKE_COUNT_WIDTH-1:0] delay_load;
  logic from_act_halt_q;
  logic from_act_halt_d;
  logic wake_service_d;
  logic wdg_reset_d;
  logic act_wake;

  assign delay_load = long_delay_option_i ?
      13'(power_mode_pkg::WAKE_DELAY_LONG_CYCLES - 1) :
      13'(power_mode_pkg::WAKE_DELAY_SHORT_CYCLES - 1);

  // Active-halt wakes on timebase or designated sources; any pending one is instant.
  assign act_wake = timebase_seen_q || halt_wake_seen_q;

  // Next mode; reset itself is the other exit path from every mode.
  always_comb begin
    mode_d          = mode_q;
    delay_d         = delay_q;
    from_act_halt_d = from_act_halt_q;
    wake_service_d  = 1'b0;
    wdg_reset_d     = 1'b0;
    case (mode_q)
      power_mode_pkg::MODE_RUN: begin
        if (halt_exec_i) begin
          if (oscillator_interrupt_enable_i) begin
            mode_d          = power_mode_pkg::MODE_ACT_HALT;
            from_act_halt_d = 1'b1;
          end else if (watchdog_enabled_i && watchdog_halt_option_i) begin
            wdg_reset_d = 1'b1;
          end else begin
            mode_d          = power_mode_pkg::MODE_FULL_HALT;
            from_act_halt_d = 1'b0;
          end
        end else if (wait_for_interrupt_i) begin
          mode_d = power_mode_pkg::MODE_WAIT;
        end
      end
      power_mode_pkg::MODE_WAIT: begin
        if (irq_any_i) begin
          mode_d         = power_mode_pkg::MODE_RUN;
          wake_service_d = 1'b1;
        end
      end
      power_mode_pkg::MODE_ACT_HALT: begin
        if (act_wake) begin
          mode_d  = power_mode_pkg::MODE_STABILISE;
          delay_d = delay_load;
        end
      end
      power_mode_pkg::MODE_FULL_HALT: begin
        if (halt_wake_seen_q) begin
          mode_d  = power_mode_pkg::MODE_STABILISE;
          delay_d = delay_load;
        end
      end
      power_mode_pkg::MODE_STABILISE: begin
        if (delay_q == 13'h0000) begin
          mode_d         = power_mode_pkg::MODE_RUN;
          wake_service_d = 1'b1;
        end else begin
          delay_d = delay_q - 13'h0001;
        end
      end
      default: begin
        mode_d = power_mode_pkg::MODE_RUN;
      end
    endcase
  end

  // State registers; reset lands in run.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q          <= power_mode_pkg::MODE_RUN;
      delay_q         <= 13'h0000;
      from_act_halt_q <= 1'b0;
    end else begin
      mode_q          <= mode_d;
      delay_q         <= delay_d;
      from_act_halt_q <= from_act_halt_d;
    end
  end

  // One-cycle answers: service start after wake, and watchdog reset request.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wake_service_o       <= 1'b0;
      watchdog_reset_req_o <= 1'b0;
    end else begin
      wake_service_o       <= wake_service_d;
      watchdog_reset_req_o <= wdg_reset_d;
    end
  end

  // ********************************************************************
  // Interrupt mask level with one-deep save
  // ********************************************************************
  // Only one nesting level is saved here; deeper nesting lives on the CPU stack.
  logic [1:0] mask_q;
  logic [1:0] mask_saved_q;

  // Priority: push, pop, forced entry value, software write.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_q       <= power_mode_pkg::MASK_LEVEL_RESET;
      mask_saved_q <= power_mode_pkg::MASK_LEVEL_RESET;
    end else if (irq_push_i) begin
      mask_saved_q <= mask_q;
      mask_q       <= irq_priority_i;
    end else if (irq_pop_i) begin
      mask_q <= mask_saved_q;
    end else if (mode_q == power_mode_pkg::MODE_RUN &&
                 mode_d != power_mode_pkg::MODE_RUN) begin
      mask_q <= power_mode_pkg::MASK_LEVEL_ALL_ENABLED;
    end else if (mask_level_wr_i) begin
      mask_q <= mask_level_wr_data_i;
    end
  end

  assign mask_level_o = mask_q;

  // ********************************************************************
  // Clock gating outputs
  // ********************************************************************
  // Enables are combinational from state so gating follows mode at once.
  always_comb begin
    cpu_clk_en_o      = 1'b0;
    periph_clk_en_o   = 1'b0;
    timebase_clk_en_o = 1'b0;
    oscillator_on_o   = 1'b1;
    case (mode_q)
      power_mode_pkg::MODE_RUN: begin
        cpu_clk_en_o      = slow_tick;
        periph_clk_en_o   = slow_tick;
        timebase_clk_en_o = 1'b1;
      end
      power_mode_pkg::MODE_WAIT: begin
        periph_clk_en_o   = slow_tick;
        timebase_clk_en_o = 1'b1;
      end
      power_mode_pkg::MODE_ACT_HALT: begin
        timebase_clk_en_o = 1'b1;
      end
      power_mode_pkg::MODE_FULL_HALT: begin
        oscillator_on_o = 1'b0;
      end
      power_mode_pkg::MODE_STABILISE: begin
        timebase_clk_en_o = from_act_halt_q;
      end
      default: begin
        oscillator_on_o = 1'b1;
      end
    endcase
  end

  // Watchdog is held off while active-halt or its wake delay runs.
  assign watchdog_suppress_o = (mode_q == power_mode_pkg::MODE_ACT_HALT) ||
      (mode_q == power_mode_pkg::MODE_STABILISE && from_act_halt_q);
  assign mode_o = mode_q;

endmodule : power_mode_controller

// *** sim/power_mode_props.sv ***
`timescale 1ns/1ns
// ************************************************************
// Checker for mode entry, clock gating and wake timing.
// ************************************************************
module power_mode_props (
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire logic       oscillator_interrupt_enable_i,
  input wire logic       long_delay_option_i,
  input wire logic       watchdog_halt_option_i,
  input wire logic       watchdog_enabled_i,
  input wire logic       wait_for_interrupt_i,
  input wire logic       halt_exec_i,
  input wire logic       irq_any_i,
  input wire logic       irq_push_i,
  input wire logic [1:0] irq_priority_i,
  input wire logic       irq_pop_i,
  input wire logic       cpu_clk_en_o,
  input wire logic       periph_clk_en_o,
  input wire logic       timebase_clk_en_o,
  input wire logic       oscillator_on_o,
  input wire logic [1:0] mask_level_o,
  input wire logic       wake_service_o,
  input wire logic       watchdog_reset_req_o,
  input wire logic       watchdog_suppress_o,
  input wire logic [2:0] mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic [12:0] stab_q;
  wire         in_run  = mode_o == 3'h0;
  wire         no_mask = !irq_push_i && !irq_pop_i;
  wire         refuse  = watchdog_enabled_i && watchdog_halt_option_i;
  wire  [12:0] lim     = long_delay_option_i ? 13'h1000 : 13'h0100;
  // Counts stabilise cycles; the count is still visible one cycle after leaving.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stab_q <= 13'h0000;
    end else begin
      stab_q <= (mode_o == 3'h4) ? stab_q + 13'h0001 : 13'h0000;
    end
  end
  sequence s_run_wake;
    (mode_o == 3'h0) ##[0:1] wake_service_o;
  endsequence
  sequence s_refuse;
    (mode_o == 3'h0) ##[0:1] watchdog_reset_req_o;
  endsequence
  a_wait_entry : assert property (
    in_run && wait_for_interrupt_i && !halt_exec_i && no_mask |=> mode_o == 3'h1 &&
    mask_level_o == 2'b10) else $error("wait entry wrong");
  a_halt_active : assert property (
    in_run && halt_exec_i && oscillator_interrupt_enable_i && no_mask |=>
    mode_o == 3'h2 && mask_level_o == 2'b10) else $error("active halt entry wrong");
  a_halt_full : assert property (
    in_run && halt_exec_i && !oscillator_interrupt_enable_i && !refuse |=>
    mode_o == 3'h3 && !oscillator_on_o) else $error("full halt entry wrong");
  a_halt_refused : assert property (
    in_run && halt_exec_i && !oscillator_interrupt_enable_i && refuse |=> s_refuse)
    else $error("halt refusal wrong");
  a_wait_gate : assert property (
    mode_o == 3'h1 |-> !cpu_clk_en_o) else $error("cpu clock runs in wait");
  a_active_gate : assert property (
    mode_o == 3'h2 |-> !cpu_clk_en_o && !periph_clk_en_o && timebase_clk_en_o &&
    oscillator_on_o && watchdog_suppress_o) else $error("active halt gating wrong");
  a_full_off : assert property (
    mode_o == 3'h3 |-> !cpu_clk_en_o && !periph_clk_en_o && !timebase_clk_en_o)
    else $error("full halt gating wrong");
  a_wait_wake : assert property (
    mode_o == 3'h1 && irq_any_i |=> s_run_wake) else $error("wait wake wrong");
  a_wake_delay : assert property (
    mode_o != 3'h4 && stab_q != 13'h0000 |-> stab_q >= lim && stab_q <= lim + 13'h0001)
    else $error("wake delay length wrong");
  a_stab_wake : assert property (
    mode_o != 3'h4 && stab_q != 13'h0000 |-> s_run_wake) else $error("no wake service");
  a_push_load : assert property (
    irq_push_i |=> mask_level_o == $past(irq_priority_i)) else $error("push mask wrong");
endmodule : power_mode_props
bind power_mode_controller power_mode_props u_power_mode_props (.*);

// *** sim/power_mode_controller_tb.sv ***
`timescale 1ns/1ns
// ************************************************************
// Directed bench: slow clock, wait, both halts and refusal.
// ************************************************************
module power_mode_controller_tb;
  logic       clk_i, arst_n_i, slow_mode_enable_i, oscillator_interrupt_enable_i;
  logic       long_delay_option_i, watchdog_halt_option_i, watchdog_enabled_i;
  logic       wait_for_interrupt_i, halt_exec_i, irq_any_i, irq_timebase_i;
  logic       irq_halt_wake_i, irq_push_i, irq_pop_i, mask_level_wr_i;
  logic [1:0] slow_divider_select_i, irq_priority_i, mask_level_wr_data_i, mask_level_o;
  logic       cpu_clk_en_o, periph_clk_en_o, timebase_clk_en_o, oscillator_on_o;
  logic       wake_service_o, watchdog_reset_req_o, watchdog_suppress_o;
  logic [2:0] mode_o;
  int         n_mismatch, num_checks, n, k;
  power_mode_controller u_power_mode_controller (.*);
  // Free-running master clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Strobes are held for exactly one edge, then sampled at the falling edge.
  task automatic pulse(input logic [4:0] p);
    @(posedge clk_i);
    {wait_for_interrupt_i, halt_exec_i, irq_push_i, irq_pop_i, mask_level_wr_i} <= p;
    @(posedge clk_i);
    {wait_for_interrupt_i, halt_exec_i, irq_push_i, irq_pop_i, mask_level_wr_i} <= 5'h00;
    @(negedge clk_i);
  endtask : pulse
  // Bounded wait for a mode; returns the number of cycles spent.
  task automatic wait_mode(input logic [2:0] m, output int c);
    c = 0;
    while (mode_o !== m && c < 9000) begin
      @(negedge clk_i);
      c++;
    end
  endtask : wait_mode
  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  // The longest path is one long wake delay; twenty thousand cycles is ample.
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  initial begin
    {slow_mode_enable_i, oscillator_interrupt_enable_i, long_delay_option_i} = 3'h0;
    {watchdog_halt_option_i, watchdog_enabled_i, irq_any_i, irq_timebase_i} = 4'h0;
    {wait_for_interrupt_i, halt_exec_i, irq_push_i, irq_pop_i, mask_level_wr_i} = 5'h00;
    {irq_halt_wake_i, slow_divider_select_i, irq_priority_i, mask_level_wr_data_i} = 7'h00;
    arst_n_i = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(negedge clk_i);
    check("mode", 16'h0, {13'h0, mode_o});
    check("cpu_en", 16'h1, {15'h0, cpu_clk_en_o});
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      slow_divider_select_i <= s[1:0];
      slow_mode_enable_i <= 1'b1;
      repeat (40) @(negedge clk_i);
      while (cpu_clk_en_o !== 1'b1 && n < 40) @(negedge clk_i);
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (cpu_clk_en_o !== 1'b1 && n < 40);
      check("cpu_gap", 16'h2 << s, n[15:0]);
    end
    pulse(5'h10);
    check("mode", 16'h1, {13'h0, mode_o});
    check("mask", 16'h2, {14'h0, mask_level_o});
    n = 0;
    k = 0;
    repeat (32) begin
      @(negedge clk_i);
      n += int'(periph_clk_en_o);
      k += int'(cpu_clk_en_o);
    end
    check("periph_ticks", 16'h2, n[15:0]);
    check("cpu_ticks", 16'h0, k[15:0]);
    @(posedge clk_i);
    irq_any_i <= 1'b1;
    slow_mode_enable_i <= 1'b0;
    @(posedge clk_i);
    irq_any_i <= 1'b0;
    @(negedge clk_i);
    check("mode", 16'h0, {13'h0, mode_o});
    check("wake_svc", 16'h1, {15'h0, wake_service_o});
    @(posedge clk_i);
    irq_priority_i <= 2'h1;
    pulse(5'h04);
    check("mask", 16'h1, {14'h0, mask_level_o});
    pulse(5'h01);
    check("mask", 16'h0, {14'h0, mask_level_o});
    pulse(5'h02);
    check("mask", 16'h2, {14'h0, mask_level_o});
    @(posedge clk_i);
    {oscillator_interrupt_enable_i, watchdog_enabled_i, watchdog_halt_option_i} <= 3'h7;
    pulse(5'h08);
    check("mode", 16'h2, {13'h0, mode_o});
    check("wdg_req", 16'h0, {15'h0, watchdog_reset_req_o});
    @(posedge clk_i);
    irq_timebase_i <= 1'b1;
    wait_mode(3'h4, n);
    @(posedge clk_i);
    irq_timebase_i <= 1'b0;
    wait_mode(3'h0, n);
    check("short_delay", 16'h1, {15'h0, n == 256 || n == 257});
    // Enable is only dropped once the wake delay has fully elapsed.
    @(posedge clk_i);
    oscillator_interrupt_enable_i <= 1'b0;
    pulse(5'h08);
    k = int'(watchdog_reset_req_o);
    @(negedge clk_i);
    k += int'(watchdog_reset_req_o);
    check("refused", 16'h8, {12'h0, k[0], mode_o});
    @(posedge clk_i);
    {watchdog_halt_option_i, long_delay_option_i} <= 2'h1;
    // Halt is only ever strobed on purpose, with the wake line held at idle.
    pulse(5'h08);
    check("full_halt", 16'h3, {12'h0, oscillator_on_o, mode_o});
    @(posedge clk_i);
    irq_timebase_i <= 1'b1;
    repeat (10) @(negedge clk_i);
    check("full_halt", 16'h3, {13'h0, mode_o});
    @(posedge clk_i);
    irq_halt_wake_i <= 1'b1;
    wait_mode(3'h4, n);
    check("osc_on", 16'h1, {15'h0, oscillator_on_o});
    @(posedge clk_i);
    irq_halt_wake_i <= 1'b0;
    wait_mode(3'h0, n);
    check("long_delay", 16'h1, {15'h0, n == 4096 || n == 4097});
    final_report();
  end
endmodule : power_mode_controller_tb
